/* File: bench/hv_prog_port_tb.sv */
// self-checking bench for the parallel programming port
// assumes prog_model plays the programmer; program times shortened to 20 clocks
`timescale 1ns/100ps
`include "hvpp_defines.svh"
module hv_prog_port_tb;
   localparam int         PROG_CYC = 20;
   localparam int         LIMIT    = 20000;
   // signature and calibration values are arbitrary
   localparam logic [7:0] SIG0     = 8'h1E;
   localparam logic [7:0] SIG1     = 8'h2D;
   localparam logic [7:0] SIG2     = 8'h4B;
   localparam logic [7:0] CAL      = 8'h69;

   logic       clk;
   logic       rst_b;
   logic       strobe, act_hi, act_lo, sel_lo, sel_hi, latch, wr_b, oe_b, drv_en;
   logic [7:0] drv_d, dev_d;
   logic       dev_oe, ready, b;
   logic [7:0] last_bus = 8'h00;
   wire  [7:0] bus;
   int         errors = 0;
   int         checks_done = 0;
   int         cycles = 0;

   // undriven bus shows the inverse of its last value, not a stale copy
   assign bus = dev_oe ? dev_d : (drv_en ? drv_d : ~last_bus);

   // plain always: errors is also counted by the compare tasks
   always @(posedge clk)
   begin
      last_bus <= bus;
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         errors++;
         wrap_up();
      end
   end

   hv_prog_port #(.FLASH_PROG_CYCLES(PROG_CYC), .EEPROM_PROG_CYCLES(PROG_CYC), .FUSE_PROG_CYCLES(PROG_CYC),
                  .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) hv_prog_port_inst
   (
      .CLK_SYS_I           (clk),
      .RST_B_I             (rst_b),
      .LOAD_STROBE_I       (strobe),
      .ACTION_SEL_HI_I     (act_hi),
      .ACTION_SEL_LO_I     (act_lo),
      .BYTE_SEL_LO_I       (sel_lo),
      .BYTE_SEL_HI_I       (sel_hi),
      .PAGE_LATCH_STROBE_I (latch),
      .WRITE_B_I           (wr_b),
      .OUT_EN_B_I          (oe_b),
      .DATA_I              (bus),
      .DATA_O              (dev_d),
      .DATA_OE_O           (dev_oe),
      .READY_BUSY_FLAG_O   (ready)
   );

   prog_model prog_model_inst
   (
      .clk_i         (clk),
      .ready_i       (ready),
      .load_strobe_o (strobe),
      .act_hi_o      (act_hi),
      .act_lo_o      (act_lo),
      .sel_lo_o      (sel_lo),
      .sel_hi_o      (sel_hi),
      .latch_o       (latch),
      .write_b_o     (wr_b),
      .out_en_b_o    (oe_b),
      .drive_en_o    (drv_en),
      .data_o        (drv_d)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] d);
      prog_model_inst.load(hvpp_pkg::ACT_CMD, 1'b0, d);
   endtask

   task automatic adr(input logic sel, input logic [7:0] d);
      prog_model_inst.load(hvpp_pkg::ACT_ADDR, sel, d);
   endtask

   task automatic dat(input logic sel, input logic [7:0] d);
      prog_model_inst.load(hvpp_pkg::ACT_DATA, sel, d);
   endtask

   task automatic rd(input logic sl, input logic sh, input logic [7:0] exp);
      prog_model_inst.look(sl, sh);
      check_bit(dev_oe, 1'b1);
      check_byte(dev_d, exp);
      prog_model_inst.unlook();
      check_bit(dev_oe, 1'b0);
   endtask

   task automatic commit(input logic sl, input logic sh, input logic exp_busy);
      prog_model_inst.wr_pulse(sl, sh);
      prog_model_inst.wait_ready(b);
      check_bit(b, exp_busy);
      check_bit(ready, 1'b1);
   endtask

   task automatic t_reset();
      check_bit(ready, 1'b1);
      check_bit(dev_oe, 1'b0);
   endtask

   task automatic t_fuses();
      cmd(`CMD_WRITE_FUSE);
      dat(1'b0, 8'hA5);
      commit(1'b0, 1'b0, 1'b1);
      dat(1'b0, 8'h3C);
      commit(1'b1, 1'b0, 1'b1);
      dat(1'b0, 8'h5A);
      commit(1'b0, 1'b1, 1'b1);
      cmd(`CMD_READ_FUSE);
      rd(1'b0, 1'b0, 8'hA5);
      rd(1'b1, 1'b1, 8'h3C);
      rd(1'b0, 1'b1, 8'h5A);
   endtask

   task automatic t_lock();
      cmd(`CMD_WRITE_LOCK);
      dat(1'b0, 8'hFC);
      commit(1'b0, 1'b0, 1'b1);
      dat(1'b0, 8'hC3);
      commit(1'b0, 1'b0, 1'b1);
      dat(1'b0, 8'hFF);
      commit(1'b0, 1'b0, 1'b1);
      cmd(`CMD_READ_FUSE);
      rd(1'b1, 1'b0, 8'hFC);
   endtask

   task automatic t_eeprom();
      cmd(`CMD_WRITE_EEPROM);
      adr(1'b1, 8'h01);
      for (int k = 0; k < 2; k++)
      begin
         adr(1'b0, 8'h04 + 8'(k));
         dat(1'b0, 8'h77 + 8'(k) * 8'h11);
         prog_model_inst.latch();
      end
      prog_model_inst.wr_pulse(1'b0, 1'b0);
      cmd(`CMD_READ_FUSE);
      prog_model_inst.wait_ready(b);
      check_bit(b, 1'b1);
      // write command must still be in force, so no read may drive the bus
      prog_model_inst.look(1'b0, 1'b0);
      check_bit(dev_oe, 1'b0);
      prog_model_inst.unlook();
      cmd(`CMD_READ_EEPROM);
      adr(1'b0, 8'h04);
      rd(1'b0, 1'b0, 8'h77);
      adr(1'b0, 8'h05);
      rd(1'b0, 1'b0, 8'h88);
   endtask

   task automatic t_flash();
      cmd(`CMD_WRITE_FLASH);
      adr(1'b0, 8'h03);
      dat(1'b0, 8'h34);
      dat(1'b1, 8'h12);
      prog_model_inst.latch();
      adr(1'b1, 8'h00);
      commit(1'b0, 1'b0, 1'b1);
      cmd(`CMD_NOP);
      dat(1'b0, 8'h99);
      prog_model_inst.latch();
      commit(1'b0, 1'b0, 1'b0);
      cmd(`CMD_READ_FLASH);
      adr(1'b1, 8'h00);
      adr(1'b0, 8'h03);
      rd(1'b0, 1'b0, 8'h34);
      rd(1'b1, 1'b0, 8'h12);
   endtask

   task automatic t_sig();
      logic [7:0] sig [3];
      sig = '{SIG0, SIG1, SIG2};
      cmd(`CMD_READ_SIG);
      for (int i = 0; i < 3; i++)
      begin
         adr(1'b0, 8'(i));
         rd(1'b0, 1'b0, sig[i]);
      end
      adr(1'b0, 8'h00);
      rd(1'b1, 1'b0, CAL);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      rst_b = 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_fuses();
      t_lock();
      t_eeprom();
      t_flash();
      t_sig();
      wrap_up();
   end
endmodule

/* File: bench/prog_model.sv */
// programmer model: drives the parallel programming pins
// assumes the bench resolves the data bus from both parties' enables
`timescale 1ns/100ps
module prog_model
(
   input  wire logic       clk_i,
   input  wire logic       ready_i,
   output logic            load_strobe_o,
   output logic            act_hi_o,
   output logic            act_lo_o,
   output logic            sel_lo_o,
   output logic            sel_hi_o,
   output logic            latch_o,
   output logic            write_b_o,
   output logic            out_en_b_o,
   output logic            drive_en_o,
   output logic [7:0]      data_o
);
   initial
   begin
      load_strobe_o = 1'b0;
      {act_hi_o, act_lo_o} = 2'h3;
      sel_lo_o = 1'b0;
      sel_hi_o = 1'b0;
      latch_o = 1'b0;
      write_b_o = 1'b1;
      out_en_b_o = 1'b1;
      data_o = 8'h00;
   end

   // bus released whenever output enable is asserted
   assign drive_en_o = out_en_b_o;

   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // every pin level held 4 clocks: the device synchronises each pin
   task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
      @(posedge clk_i);
      {act_hi_o, act_lo_o} <= act;
      sel_lo_o <= sel;
      data_o <= d;
      hold(4);
      load_strobe_o <= 1'b1;
      hold(4);
      load_strobe_o <= 1'b0;
      {act_hi_o, act_lo_o} <= 2'h3;
      hold(3);
   endtask

   task automatic latch();
      @(posedge clk_i);
      latch_o <= 1'b1;
      hold(4);
      latch_o <= 1'b0;
      hold(3);
   endtask

   task automatic wr_pulse(input logic sl, input logic sh);
      @(posedge clk_i);
      sel_lo_o <= sl;
      sel_hi_o <= sh;
      hold(4);
      write_b_o <= 1'b0;
      hold(4);
      write_b_o <= 1'b1;
   endtask

   // waits for busy to end before the next page; bounded so a stuck flag cannot hang
   task automatic wait_ready(output logic busy_seen);
      busy_seen = 1'b0;
      for (int i = 0; i < 60; i++)
      begin
         @(posedge clk_i);
         if (ready_i === 1'b0)
            busy_seen = 1'b1;
         else if (busy_seen)
            break;
      end
      sel_lo_o <= 1'b0;
      sel_hi_o <= 1'b0;
   endtask

   task automatic look(input logic sl, input logic sh);
      @(posedge clk_i);
      sel_lo_o <= sl;
      sel_hi_o <= sh;
      out_en_b_o <= 1'b0;
      hold(6);
   endtask

   task automatic unlook();
      out_en_b_o <= 1'b1;
      sel_lo_o <= 1'b0;
      sel_hi_o <= 1'b0;
      hold(6);
   endtask
endmodule

/* File: logic/hv_prog_port.sv */
// device end of the high-voltage parallel programming port
// assumes an external programmer on the pins; all pins are asynchronous
// Behaviour
// - loading the no-operation command while not busy clears the internal write enables
// - EEPROM write: command, addresses, data; page latch fills page buffer
// - write strobe with low select zero programs EEPROM page, busy meanwhile
// - Flash read with low select zero drives the word low byte
// - Flash read with low select one drives the word high byte
// - EEPROM read with low select zero drives the addressed byte
// - fuse write: data byte zero programs, one erases, committed by write strobe
// - selects 01 write high fuse, selects 00 write low fuse
// - selects 10 write the extended fuse byte
// - lock write: zero bits program lock bits, committed by write strobe
// - in lock mode 3 boot lock bits cannot be programmed
// - lock bits are never cleared by these operations
// - fuse read: selects pick low, high, extended fuse or lock byte
// - signature read drives signature byte for address 0 to 2
// - signature command, address zero, low select one drives calibration
// - load strobe action: address, data, command or nothing
// - command and address are kept between operations
`timescale 1ns/100ps
`include "hvpp_defines.svh"
module hv_prog_port
#(
   parameter int          FLASH_AW           = 13,
   parameter int          EEPROM_AW          = 9,
   parameter int          FPAGE_AW           = 6,
   parameter int          EPAGE_AW           = 2,
   parameter int          BUSY_W             = 20,
   parameter int unsigned FLASH_PROG_CYCLES  = (`T_PROG_FLASH_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int unsigned EEPROM_PROG_CYCLES = (`T_PROG_EEPROM_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int unsigned FUSE_PROG_CYCLES   = (`T_PROG_FUSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   // signature and calibration values are arbitrary
   parameter logic [7:0]  SIG_BYTE0          = 8'h5A,
   parameter logic [7:0]  SIG_BYTE1          = 8'hA5,
   parameter logic [7:0]  SIG_BYTE2          = 8'h3C,
   parameter logic [7:0]  CAL_BYTE           = 8'h80,
   parameter logic [7:0]  FUSE_LO_INIT       = 8'hFF,
   parameter logic [7:0]  FUSE_HI_INIT       = 8'hFF,
   parameter logic [7:0]  FUSE_EXT_INIT      = 8'hFF,
   parameter logic [7:0]  LOCK_INIT          = 8'hFF
)
(
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_B_I,
   input  wire logic       LOAD_STROBE_I,
   input  wire logic       ACTION_SEL_HI_I,
   input  wire logic       ACTION_SEL_LO_I,
   input  wire logic       BYTE_SEL_LO_I,
   input  wire logic       BYTE_SEL_HI_I,
   input  wire logic       PAGE_LATCH_STROBE_I,
   input  wire logic       WRITE_B_I,
   input  wire logic       OUT_EN_B_I,
   input  wire logic [7:0] DATA_I,
   output logic      [7:0] DATA_O,
   output logic            DATA_OE_O,
   output logic            READY_BUSY_FLAG_O
);

   localparam int FPAGE_N = 2 ** FPAGE_AW;
   localparam int EPAGE_N = 2 ** EPAGE_AW;

   typedef struct packed
   {
      logic              init_done;
      logic              load_prev;
      logic              latch_prev;
      logic              wr_b_prev;
      hvpp_pkg::phase_t  phase;
      logic [BUSY_W-1:0] busy_cnt;
      logic [7:0]        cmd;
      logic [7:0]        addr_hi;
      logic [7:0]        addr_lo;
      logic [7:0]        data_lo;
      logic [7:0]        data_hi;
      logic              wr_armed;
      logic [FPAGE_N-1:0] fbuf_valid;
      logic [EPAGE_N-1:0] ebuf_valid;
      logic [7:0]        fuse_lo;
      logic [7:0]        fuse_hi;
      logic [7:0]        fuse_ext;
      logic [7:0]        lock;
      logic [7:0]        dout;
      logic              dout_en;
      logic              rdy;
   } state_t;

   state_t s;
   state_t next_s;

   logic [15:0] flash_mem [2**FLASH_AW];
   logic [7:0]  eeprom_mem [2**EEPROM_AW];
   logic [15:0] fbuf [FPAGE_N];
   logic [7:0]  ebuf [EPAGE_N];

   logic [15:0] pins;
   logic        ld_rise;
   logic        latch_rise;
   logic        wr_fall;
   logic        fbuf_we;
   logic        ebuf_we;
   logic        fprog;
   logic        eprog;
   logic        bs_lo;
   logic        bs_hi;
   logic        oe_b;
   logic [7:0]  din;
   logic [15:0] word_addr;
   logic [FLASH_AW-1:0]  faddr;
   logic [EEPROM_AW-1:0] eaddr;
   hvpp_pkg::action_t    act;

   function automatic hvpp_pkg::action_t decode_action(input logic hi, input logic lo);
      case ({hi, lo})
         2'h0:    decode_action = hvpp_pkg::ACT_ADDR;
         2'h1:    decode_action = hvpp_pkg::ACT_DATA;
         2'h2:    decode_action = hvpp_pkg::ACT_CMD;
         default: decode_action = hvpp_pkg::ACT_IDLE;
      endcase
   endfunction

   function automatic logic is_read(input logic [7:0] c);
      is_read = (c == `CMD_READ_FLASH) || (c == `CMD_READ_EEPROM) ||
                (c == `CMD_READ_FUSE) || (c == `CMD_READ_SIG);
   endfunction

   // idle-high pins go to 1 at the first edge after release so no false edge shows
   pin_sync #(.W(16)) pin_sync_inst
   (
      .clk_i     (CLK_SYS_I),
      .rst_b_i   (RST_B_I),
      .async_i   ({LOAD_STROBE_I, ACTION_SEL_HI_I, ACTION_SEL_LO_I, BYTE_SEL_LO_I, BYTE_SEL_HI_I,
                   PAGE_LATCH_STROBE_I, WRITE_B_I, OUT_EN_B_I, DATA_I}),
      .rst_val_i (`PIN_IDLE_LEVELS),
      .sync_o    (pins)
   );

   assign din        = pins[`PIN_DATA_MSB:0];
   assign oe_b       = pins[`PIN_OE_B];
   assign bs_hi      = pins[`PIN_SEL_HI];
   assign bs_lo      = pins[`PIN_SEL_LO];
   assign act        = decode_action(pins[`PIN_ACT_HI], pins[`PIN_ACT_LO]);
   assign ld_rise    = s.init_done && pins[`PIN_LOAD] && !s.load_prev;
   assign latch_rise = s.init_done && pins[`PIN_LATCH] && !s.latch_prev;
   assign wr_fall    = s.init_done && !pins[`PIN_WR_B] && s.wr_b_prev;
   assign word_addr  = {s.addr_hi, s.addr_lo};
   assign faddr      = word_addr[FLASH_AW-1:0];
   assign eaddr      = word_addr[EEPROM_AW-1:0];

   always_comb
   begin
      next_s     = s;
      fbuf_we    = 1'b0;
      ebuf_we    = 1'b0;
      fprog      = 1'b0;
      eprog      = 1'b0;
      next_s.init_done  = 1'b1;
      next_s.load_prev  = pins[`PIN_LOAD];
      next_s.latch_prev = pins[`PIN_LATCH];
      next_s.wr_b_prev  = s.init_done ? pins[`PIN_WR_B] : 1'b1;
      if (s.phase == hvpp_pkg::PH_BUSY)
      begin
         if (s.busy_cnt == '0)
            next_s.phase = hvpp_pkg::PH_IDLE;
         else
            next_s.busy_cnt = s.busy_cnt - 1'b1;
      end
      // load strobe action; command and address persist until reloaded
      if (ld_rise)
      begin
         case (act)
            hvpp_pkg::ACT_CMD:
            begin
               if (s.phase == hvpp_pkg::PH_IDLE)
               begin
                  next_s.cmd      = din;
                  next_s.wr_armed = (din == `CMD_WRITE_FLASH) || (din == `CMD_WRITE_EEPROM);
               end
            end
            hvpp_pkg::ACT_ADDR:
            begin
               if (bs_lo)
                  next_s.addr_hi = din;
               else
                  next_s.addr_lo = din;
            end
            hvpp_pkg::ACT_DATA:
            begin
               if (bs_lo)
                  next_s.data_hi = din;
               else
                  next_s.data_lo = din;
            end
            default:
               next_s.cmd = s.cmd;
         endcase
      end
      if (wr_fall && s.phase == hvpp_pkg::PH_IDLE)
      begin
         case (s.cmd)
            `CMD_WRITE_FLASH:
            begin
               if (s.wr_armed)
               begin
                  fprog             = 1'b1;
                  next_s.fbuf_valid = '0;
                  next_s.phase      = hvpp_pkg::PH_BUSY;
                  next_s.busy_cnt   = BUSY_W'(FLASH_PROG_CYCLES - 1);
               end
            end
            `CMD_WRITE_EEPROM:
            begin
               if (s.wr_armed && !bs_lo)
               begin
                  eprog             = 1'b1;
                  next_s.ebuf_valid = '0;
                  next_s.phase      = hvpp_pkg::PH_BUSY;
                  next_s.busy_cnt   = BUSY_W'(EEPROM_PROG_CYCLES - 1);
               end
            end
            `CMD_WRITE_FUSE:
            begin
               next_s.phase    = hvpp_pkg::PH_BUSY;
               next_s.busy_cnt = BUSY_W'(FUSE_PROG_CYCLES - 1);
               case ({bs_hi, bs_lo})
                  `SEL_LOW:  next_s.fuse_lo  = s.data_lo;
                  `SEL_LOCK: next_s.fuse_hi  = s.data_lo;
                  `SEL_EXT:  next_s.fuse_ext = s.data_lo;
                  default:   next_s.phase    = hvpp_pkg::PH_IDLE;
               endcase
            end
            `CMD_WRITE_LOCK:
            begin
               // and-ing only programs bits; clearing needs chip erase
               next_s.lock     = s.lock & s.data_lo;
               next_s.phase    = hvpp_pkg::PH_BUSY;
               next_s.busy_cnt = BUSY_W'(FUSE_PROG_CYCLES - 1);
               if (s.lock[`LOCK_MODE_MSB:`LOCK_MODE_LSB] == `LOCK_MODE_3)
                  next_s.lock[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB] = s.lock[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB];
            end
            default:
               next_s.phase = s.phase;
         endcase
      end
      // page latch fills the slot of the low address bits; after the program clear so the set wins
      if (latch_rise && s.wr_armed && s.phase == hvpp_pkg::PH_IDLE)
      begin
         if (s.cmd == `CMD_WRITE_FLASH)
         begin
            fbuf_we = 1'b1;
            next_s.fbuf_valid[s.addr_lo[FPAGE_AW-1:0]] = 1'b1;
         end
         else if (s.cmd == `CMD_WRITE_EEPROM)
         begin
            ebuf_we = 1'b1;
            next_s.ebuf_valid[s.addr_lo[EPAGE_AW-1:0]] = 1'b1;
         end
      end
      next_s.rdy     = (next_s.phase == hvpp_pkg::PH_IDLE);
      next_s.dout_en = !oe_b && is_read(s.cmd);
      next_s.dout    = `ERASED_BYTE;
      case (s.cmd)
         `CMD_READ_FLASH:  next_s.dout = bs_lo ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
         `CMD_READ_EEPROM: next_s.dout = eeprom_mem[eaddr];
         `CMD_READ_FUSE:
         begin
            case ({bs_hi, bs_lo})
               `SEL_LOW:  next_s.dout = s.fuse_lo;
               `SEL_HIGH: next_s.dout = s.fuse_hi;
               `SEL_EXT:  next_s.dout = s.fuse_ext;
               default:   next_s.dout = s.lock;
            endcase
         end
         `CMD_READ_SIG:
         begin
            if (bs_lo)
               next_s.dout = (s.addr_lo == 8'h00) ? CAL_BYTE : `ERASED_BYTE;
            else if (s.addr_lo == 8'h00)
               next_s.dout = SIG_BYTE0;
            else if (s.addr_lo == 8'h01)
               next_s.dout = SIG_BYTE1;
            else if (s.addr_lo == `SIG_LAST)
               next_s.dout = SIG_BYTE2;
            else
               next_s.dout = `ERASED_BYTE;
         end
         default:
            next_s.dout = `ERASED_BYTE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         s          <= '0;
         s.wr_b_prev <= 1'b1;
         s.fuse_lo  <= FUSE_LO_INIT;
         s.fuse_hi  <= FUSE_HI_INIT;
         s.fuse_ext <= FUSE_EXT_INIT;
         s.lock     <= LOCK_INIT;
         s.dout     <= `ERASED_BYTE;
         s.rdy      <= 1'b1;
      end
      else
         s <= next_s;
   end

   // arrays carry no reset: flash_mem and eeprom_mem stand for the nonvolatile cells
   always_ff @(posedge CLK_SYS_I)
   begin
      if (fbuf_we)
         fbuf[s.addr_lo[FPAGE_AW-1:0]] <= {s.data_hi, s.data_lo};
      if (ebuf_we)
         ebuf[s.addr_lo[EPAGE_AW-1:0]] <= s.data_lo;
      for (int i = 0; i < FPAGE_N; i++)
         if (fprog && s.fbuf_valid[i])
            flash_mem[{faddr[FLASH_AW-1:FPAGE_AW], FPAGE_AW'(i)}] <= fbuf[i];
      for (int j = 0; j < EPAGE_N; j++)
         if (eprog && s.ebuf_valid[j])
            eeprom_mem[{eaddr[EEPROM_AW-1:EPAGE_AW], EPAGE_AW'(j)}] <= ebuf[j];
   end

   assign DATA_O            = s.dout;
   assign DATA_OE_O         = s.dout_en;
   assign READY_BUSY_FLAG_O = s.rdy;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);

   chk_nop_clears: assert property (ld_rise && act == hvpp_pkg::ACT_CMD && din == `CMD_NOP && s.rdy
      |=> !s.wr_armed) else $error("nop did not clear write enable");
   chk_eep_busy: assert property (eprog |=> !READY_BUSY_FLAG_O ##1 !READY_BUSY_FLAG_O)
      else $error("eeprom program did not go busy");
   chk_flash_lo: assert property (!oe_b && s.cmd == `CMD_READ_FLASH && !bs_lo
      |=> DATA_OE_O && DATA_O == $past(flash_mem[faddr][7:0])) else $error("flash low byte wrong");
   chk_flash_hi: assert property (!oe_b && s.cmd == `CMD_READ_FLASH && bs_lo
      |=> DATA_O == $past(flash_mem[faddr][15:8])) else $error("flash high byte wrong");
   chk_eep_read: assert property (!oe_b && s.cmd == `CMD_READ_EEPROM
      |=> DATA_O == $past(eeprom_mem[eaddr])) else $error("eeprom byte wrong");
   chk_lock_keep: assert property (##1 (s.lock & ~$past(s.lock)) == 8'h00)
      else $error("lock bit cleared");
   chk_boot_lock: assert property ($past(s.lock[`LOCK_MODE_MSB:`LOCK_MODE_LSB]) == `LOCK_MODE_3
      |-> $stable(s.lock[`BOOT_LOCK_MSB:`BOOT_LOCK_LSB]))
      else $error("boot lock changed in mode 3");
   chk_lock_read: assert property (!oe_b && s.cmd == `CMD_READ_FUSE && !bs_hi && bs_lo
      |=> DATA_O == $past(s.lock)) else $error("lock read wrong");
   chk_sig_read: assert property (!oe_b && s.cmd == `CMD_READ_SIG && !bs_lo && s.addr_lo == 8'h01
      |=> DATA_O == SIG_BYTE1) else $error("signature byte wrong");
   chk_cal_read: assert property (!oe_b && s.cmd == `CMD_READ_SIG && bs_lo && s.addr_lo == 8'h00
      |=> DATA_O == CAL_BYTE) else $error("calibration byte wrong");
   chk_bus_release: assert property (oe_b |=> !DATA_OE_O) else $error("bus driven with oe high");
   chk_busy_cmd: assert property (!s.rdy && ld_rise && act == hvpp_pkg::ACT_CMD |=> $stable(s.cmd))
      else $error("command taken while busy");

   cov_eep_prog: cover property (eprog ##[1:1000] fbuf_we);
   cov_fuse_wr: cover property (wr_fall && s.cmd == `CMD_WRITE_FUSE);
   cov_flash_rd: cover property (DATA_OE_O && s.cmd == `CMD_READ_FLASH);
   cov_lock_wr: cover property (wr_fall && s.cmd == `CMD_WRITE_LOCK);

endmodule

/* File: logic/hvpp_defines.svh */
// constants of the high-voltage parallel programming port
// assumes a single 200 MHz system clock; included by its bare name
`ifndef HVPP_DEFINES_SVH
`define HVPP_DEFINES_SVH

`define CLK_PERIOD_NS      5
`define T_PROG_FLASH_US    2600
`define T_PROG_EEPROM_US   3600
`define T_PROG_FUSE_US     4500

`define CMD_NOP            8'h00
`define CMD_WRITE_FUSE     8'h40
`define CMD_WRITE_LOCK     8'h20
`define CMD_WRITE_FLASH    8'h10
`define CMD_WRITE_EEPROM   8'h11
`define CMD_READ_SIG       8'h08
`define CMD_READ_FUSE      8'h04
`define CMD_READ_FLASH     8'h02
`define CMD_READ_EEPROM    8'h03

`define SEL_LOW            2'h0
`define SEL_LOCK           2'h1
`define SEL_EXT            2'h2
`define SEL_HIGH           2'h3

`define LOCK_MODE_LSB      0
`define LOCK_MODE_MSB      1
`define BOOT_LOCK_LSB      2
`define BOOT_LOCK_MSB      5
`define LOCK_MODE_3        2'h0
`define SIG_LAST           8'h02
`define ERASED_BYTE        8'hFF

`define PIN_DATA_MSB       7
`define PIN_OE_B           8
`define PIN_WR_B           9
`define PIN_LATCH          10
`define PIN_SEL_HI         11
`define PIN_SEL_LO         12
`define PIN_ACT_LO         13
`define PIN_ACT_HI         14
`define PIN_LOAD           15
// idle pin levels: action select 11, write and output enable high, the rest low
`define PIN_IDLE_LEVELS    16'h6300

`endif

/* File: logic/hvpp_pkg.sv */
// types shared by the parallel programming port
// no assumptions beyond the defines header
package hvpp_pkg;

   typedef enum logic [1:0]
   {
      ACT_ADDR,
      ACT_DATA,
      ACT_CMD,
      ACT_IDLE
   } action_t;

   typedef enum logic
   {
      PH_IDLE,
      PH_BUSY
   } phase_t;

endpackage

/* File: logic/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
// assumes the group holds independent levels; no bus coherence implied
`timescale 1ns/100ps
module pin_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] async_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
      logic         run;
   } sync_t;

   sync_t s;
   sync_t next_s;

   always_comb
   begin
      next_s.run    = 1'b1;
      // idle levels stand in for one edge so no false edge follows reset
      next_s.meta   = s.run ? async_i : rst_val_i;
      next_s.stable = s.run ? s.meta : rst_val_i;
   end

   // reset value is a constant; rst_val_i is applied one edge after release
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign sync_o = s.stable;

endmodule
